// ==== rtl/cas_status_bank.sv ====
`timescale 1ns/1ps
// Summary of operation
// [RL1] Reference near lock at limit over sixteen
// [RL2] Live acquiring, locked, holdover reference bits
// [RL3] Sync request when locked or disabled but unsynchronized
// [RL4] Combined lock only when both loops lock
// [RL5] Phase status shows SYSREF output stable
// [RL6] Never-synced reads one until first sync
// [RL7] Synthesis near lock at limit over sixteen
// [RL8] Latch acquisition and holdover until clear
// [RL9] Latch per-input loss of signal until clear
// [RL10] Report reference loop state code
// [RL11] Report preferred reference index
// [RL12] Report active reference index
// [RL13] Expose averaged, current DAC and comparator
// [RL14] Flag loss of signal on active reference
// [RL15] Flag reference faster than crystal oscillator
// [RL16] ADC status: acquiring or moving quickly
// [RL17] ADC range: in or out of range
// [RL18] Report holdover exit phase
// [RL19] Masked live conditions form combined alarm
// [RL20] Combined alarm readable as bit zero
// [RL21] Latched bits hold until clear event
// [RL22] Read-only, reserved zero, writes ignored
module cas_status_bank #(
  parameter int LCW = cas_pkg::LOCK_COUNT_WIDTH
) (
  input  wire logic           CLK_SYS,
  input  wire logic           NRST,
  input  wire logic [LCW-1:0] REF_LOCK_COUNT,
  input  wire logic [LCW-1:0] REF_LOCK_LIMIT,
  input  wire logic [LCW-1:0] SYN_LOCK_COUNT,
  input  wire logic [LCW-1:0] SYN_LOCK_LIMIT,
  input  wire logic [2:0]     REF_LOOP_STATE,
  input  wire logic [3:0]     REF_LOS,
  input  wire logic           SYN_LOCKED,
  input  wire logic           SYN_ACQUIRING,
  input  wire logic           SYN_DISABLED,
  input  wire logic           SYSREF_PHASE_STABLE,
  input  wire logic           SYNC_PIN,
  input  wire logic           SYNC_REQUEST_PORT,
  input  wire logic [1:0]     PREFERRED_REF_INDEX,
  input  wire logic [1:0]     ACTIVE_REF_INDEX,
  input  wire logic [6:0]     DAC_AVERAGED_CODE,
  input  wire logic [6:0]     DAC_CURRENT_CODE,
  input  wire logic           DAC_COMPARATOR,
  input  wire logic           REF_FASTER_THAN_VCXO,
  input  wire logic           ADC_TUNE_MOVING,
  input  wire logic           ADC_OUT_OF_RANGE,
  input  wire logic [1:0]     EXIT_PHASE,
  input  wire logic           LATCH_CLEAR,
  input  wire logic [7:0]     REF_ALARM_MASK,
  input  wire logic [4:0]     COMBINED_ALARM_MASK,
  input  wire logic [7:0]     REG_ADDR,
  input  wire logic           REG_RD,
  input  wire logic           REG_WR,
  output logic      [7:0]     REG_RDATA,
  output logic                REG_RVALID,
  output logic                ALARM
);

  // ==========================================================
  // State record
  typedef struct packed {
    logic       sync_s1;
    logic       sync_s2;
    logic       sync_s3;
    logic       sync_level;
    logic       synced;
    logic [7:0] live_ref;
    logic [7:0] live_comb;
    logic [7:0] latched;
    logic [7:0] state_sel;
    logic [7:0] dac_avg;
    logic [7:0] dac_cur;
    logic [7:0] adc_stat;
    logic [7:0] exit_phase;
    logic       alarm;
    logic [7:0] rdata;
    logic       rvalid;
  } cas_state_s;

  cas_state_s st_reg;
  cas_state_s st_next;

  // ==========================================================
  // Decoding helpers
  function automatic logic ref_state_is(input logic [2:0] code, input logic [2:0] want);
    ref_state_is = (code == want);
  endfunction

  function automatic logic ref_in_holdover(input logic [2:0] code);
    // DAC assisted exit is still holdover until it hands back to lock
    ref_in_holdover = ref_state_is(code, cas_pkg::REF_ST_HOLDOVER) ||
                      ref_state_is(code, cas_pkg::REF_ST_DAC_EXIT);
  endfunction

  // ==========================================================
  // Near lock detection for both loops
  cas_near_lock_if #(.CW(LCW)) nl_bus ();

  assign nl_bus.count[cas_pkg::LOOP_REF] = REF_LOCK_COUNT;
  assign nl_bus.count[cas_pkg::LOOP_SYN] = SYN_LOCK_COUNT;
  assign nl_bus.limit[cas_pkg::LOOP_REF] = REF_LOCK_LIMIT;
  assign nl_bus.limit[cas_pkg::LOOP_SYN] = SYN_LOCK_LIMIT;

  cas_near_lock #(
    .CW   (LCW)
  ) u_near_lock (
    .clk  (CLK_SYS),
    .nrst (NRST),
    .nl   (nl_bus.detect)
  );

  // ==========================================================
  // Next state
  logic       ref_acq;
  logic       ref_lock;
  logic       ref_hold;
  logic       sync_rise;
  logic       synced_now;
  logic       rd_take;
  logic [7:0] live_ref_c;
  logic [7:0] live_comb_c;
  logic [7:0] latch_set;
  logic [7:0] rd_mux;

  always_comb begin
    st_next = st_reg;

    ref_acq  = ref_state_is(REF_LOOP_STATE, cas_pkg::REF_ST_ACQUIRE);  // see [RL2]
    ref_lock = ref_state_is(REF_LOOP_STATE, cas_pkg::REF_ST_LOCKED);   // see [RL2]
    ref_hold = ref_in_holdover(REF_LOOP_STATE);                        // see [RL2]

    // Sync pin: three stages, change taken once stages two and three agree
    st_next.sync_s1 = SYNC_PIN;
    st_next.sync_s2 = st_reg.sync_s1;
    st_next.sync_s3 = st_reg.sync_s2;
    if (st_reg.sync_s2 == st_reg.sync_s3) begin
      st_next.sync_level = st_reg.sync_s2;
    end
    sync_rise = (st_reg.sync_s2 == st_reg.sync_s3) && st_reg.sync_s2 && !st_reg.sync_level;

    // Synchronized state is sticky; only reset brings back never-synced
    synced_now = st_reg.synced || sync_rise || SYNC_REQUEST_PORT;    // see [RL6]
    st_next.synced = synced_now;

    live_ref_c = cas_pkg::STATUS_RESET;
    live_ref_c[cas_pkg::BIT_REF_NEAR_LOCK] = nl_bus.near[cas_pkg::LOOP_REF]; // see [RL1]
    live_ref_c[cas_pkg::BIT_REF_ACQUIRING] = ref_acq;                        // see [RL2]
    live_ref_c[cas_pkg::BIT_REF_LOCKED]    = ref_lock;                       // see [RL2]
    live_ref_c[cas_pkg::BIT_REF_HOLDOVER]  = ref_hold;                       // see [RL2]
    live_ref_c[cas_pkg::NUM_REF_INPUTS-1:0] = REF_LOS;
    st_next.live_ref = live_ref_c;

    live_comb_c = cas_pkg::STATUS_RESET;
    live_comb_c[cas_pkg::BIT_SYNC_REQUEST] =
      (SYN_LOCKED || SYN_DISABLED) && !st_reg.synced;                        // see [RL3]
    live_comb_c[cas_pkg::BIT_BOTH_LOCKED]  = ref_lock && SYN_LOCKED;         // see [RL4]
    live_comb_c[cas_pkg::BIT_PHASE_STABLE] = SYSREF_PHASE_STABLE;            // see [RL5]
    live_comb_c[cas_pkg::BIT_NEVER_SYNCED] = !st_reg.synced;                 // see [RL6]
    live_comb_c[cas_pkg::BIT_SYN_NEAR_LOCK] = nl_bus.near[cas_pkg::LOOP_SYN]; // see [RL7]
    st_next.live_comb = live_comb_c;

    // Latched records: a new event in the clear cycle survives the clear
    latch_set = cas_pkg::STATUS_RESET;
    latch_set[cas_pkg::BIT_LAT_SYN_ACQ]  = SYN_ACQUIRING;                    // see [RL8]
    latch_set[cas_pkg::BIT_LAT_REF_ACQ]  = ref_acq;                          // see [RL8]
    latch_set[cas_pkg::BIT_LAT_HOLDOVER] = ref_hold;                         // see [RL8]
    latch_set[cas_pkg::NUM_REF_INPUTS-1:0] = REF_LOS;                        // see [RL9]
    if (LATCH_CLEAR) begin
      st_next.latched = latch_set;                                           // see [RL21]
    end else begin
      st_next.latched = st_reg.latched | latch_set;                          // see [RL21]
    end

    st_next.state_sel = cas_pkg::STATUS_RESET;
    st_next.state_sel[cas_pkg::LSB_PREFERRED_REF +: 2] = PREFERRED_REF_INDEX; // see [RL11]
    st_next.state_sel[cas_pkg::LSB_ACTIVE_REF +: 2]    = ACTIVE_REF_INDEX;    // see [RL12]
    st_next.state_sel[2:0] = REF_LOOP_STATE;                                  // see [RL10]

    st_next.dac_avg = {1'b0, DAC_AVERAGED_CODE};                              // see [RL13]
    st_next.dac_cur = cas_pkg::STATUS_RESET;
    st_next.dac_cur[cas_pkg::BIT_DAC_COMPARATOR] = DAC_COMPARATOR;            // see [RL13]
    st_next.dac_cur[cas_pkg::DAC_CODE_WIDTH-1:0] = DAC_CURRENT_CODE;          // see [RL13]

    st_next.adc_stat = cas_pkg::STATUS_RESET;
    st_next.adc_stat[cas_pkg::BIT_ACTIVE_LOS]    = REF_LOS[ACTIVE_REF_INDEX]; // see [RL14]
    st_next.adc_stat[cas_pkg::BIT_REF_FASTER]    = REF_FASTER_THAN_VCXO;      // see [RL15]
    st_next.adc_stat[cas_pkg::BIT_ADC_FAST]      = ADC_TUNE_MOVING;           // see [RL16]
    st_next.adc_stat[cas_pkg::BIT_ADC_OUT_RANGE] = ADC_OUT_OF_RANGE;          // see [RL17]

    st_next.exit_phase = cas_pkg::STATUS_RESET;
    st_next.exit_phase[cas_pkg::LSB_EXIT_PHASE +: 2] = EXIT_PHASE;            // see [RL18]

    // Alarm follows the registered live bits, one cycle behind them
    st_next.alarm = (|(st_reg.live_ref & REF_ALARM_MASK)) ||
                    (|(st_reg.live_comb[cas_pkg::COMBINED_LIVE_WIDTH-1:0] &
                       COMBINED_ALARM_MASK));                                 // see [RL19]

    // Register reads: a write strobe cancels the read and changes nothing
    rd_take = REG_RD && !REG_WR;                                              // see [RL22]
    case (REG_ADDR)
      cas_pkg::ADDR_COMBINED_ALARM_OUT:  rd_mux = {7'h00, st_reg.alarm};      // see [RL20]
      cas_pkg::ADDR_LOOP_A_ALARM_LIVE:   rd_mux = st_reg.live_ref;
      cas_pkg::ADDR_COMBINED_ALARM_LIVE: rd_mux = st_reg.live_comb;
      cas_pkg::ADDR_ALARM_LATCHED:       rd_mux = st_reg.latched;
      cas_pkg::ADDR_LOOP_A_STATE_SELECT: rd_mux = st_reg.state_sel;
      cas_pkg::ADDR_HOLDOVER_DAC_AVG:    rd_mux = st_reg.dac_avg;
      cas_pkg::ADDR_HOLDOVER_DAC_CUR:    rd_mux = st_reg.dac_cur;
      cas_pkg::ADDR_HOLDOVER_ADC_STATUS: rd_mux = st_reg.adc_stat;
      cas_pkg::ADDR_HOLDOVER_EXIT_PHASE: rd_mux = st_reg.exit_phase;
      default:                           rd_mux = cas_pkg::STATUS_RESET;      // see [RL22]
    endcase

    st_next.rvalid = rd_take;
    if (rd_take) begin
      st_next.rdata = rd_mux;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign REG_RDATA  = st_reg.rdata;
  assign REG_RVALID = st_reg.rvalid;
  assign ALARM      = st_reg.alarm;

endmodule // cas_status_bank

// ==== rtl/cas_pkg.sv ====
package cas_pkg;

  // ==========================================================
  // Register byte addresses on the serial control port
  localparam logic [7:0] ADDR_COMBINED_ALARM_OUT  = 8'h7B;
  localparam logic [7:0] ADDR_LOOP_A_ALARM_LIVE   = 8'h7C;
  localparam logic [7:0] ADDR_COMBINED_ALARM_LIVE = 8'h7D;
  localparam logic [7:0] ADDR_ALARM_LATCHED       = 8'h7E;
  localparam logic [7:0] ADDR_ALARM_MISC_RSVD     = 8'h7F;
  localparam logic [7:0] ADDR_LOOP_A_STATE_SELECT = 8'h82;
  localparam logic [7:0] ADDR_HOLDOVER_DAC_AVG    = 8'h83;
  localparam logic [7:0] ADDR_HOLDOVER_DAC_CUR    = 8'h84;
  localparam logic [7:0] ADDR_HOLDOVER_ADC_STATUS = 8'h85;
  localparam logic [7:0] ADDR_HOLDOVER_EXIT_PHASE = 8'h86;
  localparam logic [7:0] ADDR_LOOP_A_STATUS_RSVD  = 8'h87;

  // ==========================================================
  // Field positions, reference loop live alarms
  localparam int BIT_REF_NEAR_LOCK   = 7;
  localparam int BIT_REF_ACQUIRING   = 6;
  localparam int BIT_REF_LOCKED      = 5;
  localparam int BIT_REF_HOLDOVER    = 4;
  localparam int NUM_REF_INPUTS      = 4;

  // Field positions, combined live alarms
  localparam int BIT_SYNC_REQUEST    = 4;
  localparam int BIT_BOTH_LOCKED     = 3;
  localparam int BIT_PHASE_STABLE    = 2;
  localparam int BIT_NEVER_SYNCED    = 1;
  localparam int BIT_SYN_NEAR_LOCK   = 0;
  localparam int COMBINED_LIVE_WIDTH = 5;

  // Field positions, latched record
  localparam int BIT_LAT_SYN_ACQ     = 6;
  localparam int BIT_LAT_REF_ACQ     = 5;
  localparam int BIT_LAT_HOLDOVER    = 4;

  // Field positions, holdover ADC status and holdover DAC current registers
  localparam int BIT_ACTIVE_LOS      = 3;
  localparam int BIT_REF_FASTER      = 2;
  localparam int BIT_ADC_FAST        = 1;
  localparam int BIT_ADC_OUT_RANGE   = 0;
  localparam int BIT_DAC_COMPARATOR  = 7;
  localparam int DAC_CODE_WIDTH      = 7;

  // Field positions, state and selection register and holdover exit phase register
  localparam int LSB_PREFERRED_REF   = 5;
  localparam int LSB_ACTIVE_REF      = 3;
  localparam int LSB_EXIT_PHASE      = 3;

  // ==========================================================
  // Reference loop state codes
  localparam logic [2:0] REF_ST_RESET     = 3'h0;
  localparam logic [2:0] REF_ST_ACQUIRE   = 3'h1;
  localparam logic [2:0] REF_ST_LOCKED    = 3'h2;
  localparam logic [2:0] REF_ST_INVALID   = 3'h3;
  localparam logic [2:0] REF_ST_HOLDOVER  = 3'h4;
  localparam logic [2:0] REF_ST_DAC_EXIT  = 3'h5;

  // ==========================================================
  // Near lock threshold is limit / 16
  localparam int NEAR_LOCK_SHIFT     = 4;
  localparam int NUM_LOOPS           = 2;
  localparam int LOOP_REF            = 0;
  localparam int LOOP_SYN            = 1;
  localparam int LOCK_COUNT_WIDTH    = 16;

  // Reset value of all status readback registers
  localparam logic [7:0] STATUS_RESET = 8'h00;

endpackage

// ==== rtl/cas_near_lock_if.sv ====
`timescale 1ns/1ps
interface cas_near_lock_if #(
  parameter int CW = cas_pkg::LOCK_COUNT_WIDTH
);
  logic [cas_pkg::NUM_LOOPS-1:0][CW-1:0] count;
  logic [cas_pkg::NUM_LOOPS-1:0][CW-1:0] limit;
  logic [cas_pkg::NUM_LOOPS-1:0]         near;

  modport bank   (output count, output limit, input near);
  modport detect (input count, input limit, output near);
endinterface

// ==== rtl/cas_near_lock.sv ====
`timescale 1ns/1ps
module cas_near_lock #(
  parameter int CW = cas_pkg::LOCK_COUNT_WIDTH
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  cas_near_lock_if.detect       nl
);

  // ==========================================================
  // Per-loop threshold compare, registered
  logic [cas_pkg::NUM_LOOPS-1:0] near_reg;
  logic [cas_pkg::NUM_LOOPS-1:0] near_next;

  genvar g;
  generate
    for (g = 0; g < cas_pkg::NUM_LOOPS; g++) begin : g_loop
      // Shift truncates, so a limit under 16 gives near lock at once
      assign near_next[g] = (nl.count[g] >= (nl.limit[g] >> cas_pkg::NEAR_LOCK_SHIFT)); // see [RL1] [RL7]
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      near_reg <= '0;
    end else begin
      near_reg <= near_next;
    end
  end

  assign nl.near = near_reg;

endmodule // cas_near_lock

// ==== verification/cas_status_bank_assertions.sv ====
`timescale 1ns/1ps
module cas_status_bank_chk (
  input wire logic       CLK_SYS,
  input wire logic       NRST,
  input wire logic [7:0] REG_ADDR,
  input wire logic       REG_RD,
  input wire logic       REG_WR,
  input wire logic [7:0] REG_RDATA,
  input wire logic       REG_RVALID,
  input wire logic       ALARM,
  input wire logic [2:0] REF_LOOP_STATE,
  input wire logic       SYN_LOCKED,
  input wire logic [1:0] PREFERRED_REF_INDEX,
  input wire logic [1:0] ACTIVE_REF_INDEX,
  input wire logic [7:0] REF_ALARM_MASK,
  input wire logic [4:0] COMBINED_ALARM_MASK
);
  // ==========================================================
  // Read port and readback relations
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  logic       rd;
  logic [6:0] sel;
  assign rd  = REG_RD && !REG_WR;
  assign sel = {PREFERRED_REF_INDEX, ACTIVE_REF_INDEX, REF_LOOP_STATE};

  a_read_answered: assert property (rd |=> REG_RVALID)
    else $error("read not answered");
  a_write_ignored: assert property (REG_WR |=> !REG_RVALID)
    else $error("write produced read data");
  a_rdata_holds: assert property (!rd |=> $stable(REG_RDATA))
    else $error("read data moved without a read");
  a_rsvd_zero: assert property (rd && (REG_ADDR == 8'h7F || REG_ADDR == 8'h87)
    |=> REG_RDATA == 8'h00) else $error("reserved register not zero");
  a_both_locked: assert property (rd && REG_ADDR == 8'h7D && $stable(sel) &&
    $stable(SYN_LOCKED)
    |=> REG_RDATA[3] == ($past(REF_LOOP_STATE) == 3'h2 && $past(SYN_LOCKED)))
    else $error("combined lock bit wrong");
  a_state_select: assert property (rd && REG_ADDR == 8'h82 && $stable(sel)
    |=> REG_RDATA == {1'b0, $past(sel)}) else $error("state register wrong");
  // Codes 6 and 7 are undefined, so only 4 and 5 count as holdover
  a_ref_live: assert property (rd && REG_ADDR == 8'h7C && $stable(sel)
    |=> REG_RDATA[6:4] == {$past(REF_LOOP_STATE) == 3'h1, $past(REF_LOOP_STATE) == 3'h2,
    ($past(REF_LOOP_STATE) == 3'h4 || $past(REF_LOOP_STATE) == 3'h5)})
    else $error("live loop bits wrong");
  a_alarm_masked: assert property (
    (REF_ALARM_MASK == 8'h00 && COMBINED_ALARM_MASK == 5'h00)[*4]
    |-> !ALARM) else $error("alarm with all masks clear");

  c_read: cover property (rd ##1 REG_RVALID);
  c_alarm: cover property (!ALARM ##1 ALARM);
  c_write: cover property (REG_WR && REG_RD);
endmodule // cas_status_bank_chk

bind cas_status_bank cas_status_bank_chk i_chk (
  .CLK_SYS, .NRST, .REG_ADDR, .REG_RD, .REG_WR, .REG_RDATA, .REG_RVALID, .ALARM,
  .REF_LOOP_STATE, .SYN_LOCKED, .PREFERRED_REF_INDEX, .ACTIVE_REF_INDEX,
  .REF_ALARM_MASK, .COMBINED_ALARM_MASK
);

// ==== verification/cas_status_bank_bench.sv ====
`timescale 1ns/1ps
module cas_status_bank_bench;
  // ==========================================================
  // Stimulus, instance and shared tasks
  logic        CLK_SYS = 1'b0;
  logic        NRST = 1'b0;
  logic [15:0] REF_LOCK_COUNT, REF_LOCK_LIMIT, SYN_LOCK_COUNT, SYN_LOCK_LIMIT;
  logic [2:0]  REF_LOOP_STATE;
  logic [3:0]  REF_LOS;
  logic [1:0]  PREFERRED_REF_INDEX, ACTIVE_REF_INDEX, EXIT_PHASE;
  logic [6:0]  DAC_AVERAGED_CODE, DAC_CURRENT_CODE;
  logic [7:0]  REF_ALARM_MASK, REG_ADDR, REG_RDATA;
  logic [4:0]  COMBINED_ALARM_MASK;
  logic        SYN_LOCKED, SYN_ACQUIRING, SYN_DISABLED, SYSREF_PHASE_STABLE, SYNC_PIN;
  logic        SYNC_REQUEST_PORT, DAC_COMPARATOR, REF_FASTER_THAN_VCXO, ADC_TUNE_MOVING;
  logic        ADC_OUT_OF_RANGE, LATCH_CLEAR, REG_RD, REG_WR, REG_RVALID, ALARM;
  int          err_total;
  int          checks;

  always #12.5 CLK_SYS = ~CLK_SYS;

  cas_status_bank #(.LCW(16)) i_dut (
    .CLK_SYS, .NRST, .REF_LOCK_COUNT, .REF_LOCK_LIMIT, .SYN_LOCK_COUNT, .SYN_LOCK_LIMIT,
    .REF_LOOP_STATE, .REF_LOS, .SYN_LOCKED, .SYN_ACQUIRING, .SYN_DISABLED,
    .SYSREF_PHASE_STABLE, .SYNC_PIN, .SYNC_REQUEST_PORT, .PREFERRED_REF_INDEX,
    .ACTIVE_REF_INDEX, .DAC_AVERAGED_CODE, .DAC_CURRENT_CODE, .DAC_COMPARATOR,
    .REF_FASTER_THAN_VCXO, .ADC_TUNE_MOVING, .ADC_OUT_OF_RANGE, .EXIT_PHASE,
    .LATCH_CLEAR, .REF_ALARM_MASK, .COMBINED_ALARM_MASK, .REG_ADDR, .REG_RD, .REG_WR,
    .REG_RDATA, .REG_RVALID, .ALARM
  );

  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Waits five edges; the longest path, the sync pin into ALARM, takes six
  task automatic wt();
    repeat (5) @(posedge CLK_SYS);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge CLK_SYS);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    // Look at the answer mid-cycle, never in the edge that launches it
    @(negedge CLK_SYS);
    for (int i = 0; i < 3 && REG_RVALID !== 1'b1; i++) @(negedge CLK_SYS);
    chk("rvalid", {7'h0, REG_RVALID}, 8'h01);
    if (REG_RVALID !== 1'b1) report_and_stop();
    else chk(n, REG_RDATA, e);
  endtask

  // ==========================================================
  // Scenarios
  task automatic s_map();
    rd(8'h7F, 8'h00, "rsvd_7f");
    rd(8'h87, 8'h00, "rsvd_87");
    rd(8'h00, 8'h00, "unmapped");
    @(posedge CLK_SYS);
    {REG_RD, REG_WR} <= 2'h3;
    @(posedge CLK_SYS);
    {REG_RD, REG_WR} <= 2'h0;
    @(negedge CLK_SYS);
    chk("wr_rvalid", {7'h0, REG_RVALID}, 8'h00);
    for (int p = 0; p < 4; p++) begin
      @(posedge CLK_SYS);
      EXIT_PHASE <= p[1:0];
      wt();
      rd(8'h86, {3'h0, p[1:0], 3'h0}, "exit_phase");
    end
  endtask

  task automatic s_ref();
    for (int i = 0; i < 6; i++) begin
      @(posedge CLK_SYS);
      REF_LOOP_STATE <= i[2:0];
      wt();
      rd(8'h82, {3'h2, 2'h1, i[2:0]}, "state");
      rd(8'h7C, {1'b0, i == 1, i == 2, i >= 4, 4'h0}, "ref_live");
    end
    @(posedge CLK_SYS);
    REF_LOCK_COUNT <= 16'h0010;
    SYN_LOCK_COUNT <= 16'h0010;
    wt();
    rd(8'h7C, 8'h90, "near_lock");
  endtask

  task automatic s_latch();
    @(posedge CLK_SYS);
    REF_LOOP_STATE <= 3'h0;
    wt();
    LATCH_CLEAR <= 1'b1;
    @(posedge CLK_SYS);
    LATCH_CLEAR <= 1'b0;
    wt();
    rd(8'h7E, 8'h00, "lat_clear");
    @(posedge CLK_SYS);
    {REF_LOS, SYN_ACQUIRING, REF_LOOP_STATE} <= {4'h5, 1'b1, 3'h1};
    @(posedge CLK_SYS);
    {REF_LOS, SYN_ACQUIRING, REF_LOOP_STATE} <= {4'h0, 1'b0, 3'h4};
    @(posedge CLK_SYS);
    REF_LOOP_STATE <= 3'h2;
    wt();
    rd(8'h7E, 8'h75, "lat_held");
    // A loss in the clear cycle must survive the clear
    @(posedge CLK_SYS);
    {LATCH_CLEAR, REF_LOS} <= {1'b1, 4'h8};
    @(posedge CLK_SYS);
    {LATCH_CLEAR, REF_LOS} <= {1'b0, 4'h0};
    wt();
    rd(8'h7E, 8'h08, "lat_again");
  endtask

  task automatic s_comb();
    logic [7:0] exp_live [4];
    exp_live = '{8'h03, 8'h1F, 8'h13, 8'h1F};
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK_SYS);
      {SYN_DISABLED, SYN_LOCKED, SYSREF_PHASE_STABLE} <= {i[1:0], i[0]};
      wt();
      rd(8'h7D, exp_live[i], "comb_live");
    end
    @(posedge CLK_SYS);
    SYNC_REQUEST_PORT <= 1'b1;
    @(posedge CLK_SYS);
    SYNC_REQUEST_PORT <= 1'b0;
    wt();
    rd(8'h7D, 8'h0D, "comb_synced");
  endtask

  // Only reset re-arms never-synced, so the pin path needs one mid-run
  task automatic s_pin();
    @(posedge CLK_SYS);
    NRST <= 1'b0;
    repeat (10) @(posedge CLK_SYS);
    NRST <= 1'b1;
    wt();
    rd(8'h7D, 8'h1F, "pin_never");
    @(posedge CLK_SYS);
    SYNC_PIN <= 1'b1;
    wt();
    SYNC_PIN <= 1'b0;
    wt();
    rd(8'h7D, 8'h0D, "pin_synced");
  endtask

  task automatic s_hold();
    @(posedge CLK_SYS);
    {DAC_AVERAGED_CODE, DAC_CURRENT_CODE, DAC_COMPARATOR, REF_LOS} <= {7'h55, 7'h2A, 1'b1, 4'h4};
    wt();
    rd(8'h83, 8'h55, "dac_avg");
    rd(8'h84, 8'hAA, "dac_cur");
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK_SYS);
      ACTIVE_REF_INDEX <= i[1:0];
      {REF_FASTER_THAN_VCXO, ADC_TUNE_MOVING, ADC_OUT_OF_RANGE} <= {i[0], i[1], i[0] ^ i[1]};
      wt();
      rd(8'h85, {4'h0, i == 2, i[0], i[1], i[0] ^ i[1]}, "adc");
    end
  endtask

  task automatic s_alarm();
    @(posedge CLK_SYS);
    {REF_LOS, REF_ALARM_MASK, COMBINED_ALARM_MASK} <= {4'h1, 8'h00, 5'h00};
    wt();
    @(negedge CLK_SYS);
    chk("alarm_off", {7'h0, ALARM}, 8'h00);
    @(posedge CLK_SYS);
    REF_ALARM_MASK <= 8'h01;
    wt();
    @(negedge CLK_SYS);
    chk("alarm_los", {7'h0, ALARM}, 8'h01);
    rd(8'h7B, 8'h01, "alarm_rb");
    @(posedge CLK_SYS);
    REF_ALARM_MASK <= 8'h02;
    wt();
    rd(8'h7B, 8'h00, "alarm_other");
    @(posedge CLK_SYS);
    COMBINED_ALARM_MASK <= 5'h04;
    wt();
    @(negedge CLK_SYS);
    chk("alarm_phase", {7'h0, ALARM}, 8'h01);
  endtask

  initial begin
    {REF_LOOP_STATE, REF_LOS, EXIT_PHASE} = '0;
    {DAC_AVERAGED_CODE, DAC_CURRENT_CODE, REF_ALARM_MASK, REG_ADDR, COMBINED_ALARM_MASK} = '0;
    {SYN_LOCKED, SYN_ACQUIRING, SYN_DISABLED, SYSREF_PHASE_STABLE, SYNC_PIN} = '0;
    {SYNC_REQUEST_PORT, DAC_COMPARATOR, REF_FASTER_THAN_VCXO, ADC_TUNE_MOVING} = '0;
    {ADC_OUT_OF_RANGE, LATCH_CLEAR, REG_RD, REG_WR} = '0;
    {REF_LOCK_LIMIT, SYN_LOCK_LIMIT} = {16'h0100, 16'h0100};
    {REF_LOCK_COUNT, SYN_LOCK_COUNT} = {16'h000F, 16'h000F};
    {PREFERRED_REF_INDEX, ACTIVE_REF_INDEX} = {2'h2, 2'h1};
    err_total = 0;
    checks = 0;
    repeat (10) @(posedge CLK_SYS);
    NRST <= 1'b1;
    wt();
    s_map();
    s_ref();
    s_latch();
    s_comb();
    s_pin();
    s_hold();
    s_alarm();
    report_and_stop();
  end
endmodule // cas_status_bank_bench
